//--- hdl/ppfm_port_mux.sv
// Two general-purpose ports (8 and 6 pins, 8-bit registers) with per-bit function select, APB register slave.
// Assumes pin inputs and timer signals synchronous to pclk; pad logic resolves pin levels from enables.
//
// Function
// - Pin output enable always follows the bit's own direction bit.
// - Port 1 bit 0 selected: module output low, pin feeds timer external clock.
// - Port 1 bits 1-3 selected: compare outputs 0-2 out, first capture inputs in.
// - Port 2 bit 0 selected: auxiliary clock driven onto pin, input unused.
// - Port 2 bit 1 selected: module output low, pin feeds timer alternate clock.
// - Port 2 bits 2-4: compare outputs 0-2 out; bits 2,3 feed second captures.
// - Port 2 bits 6,7 keep all control bits, module output low, input unused.
// - Flags of port 2 bits 6,7 change only by software writes.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps

module ppfm_port_mux
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  input wire logic [5:0] p2_in,
  output logic [5:0] p2_out,
  output logic [5:0] p2_oe,
  input wire logic timer_compare_output_zero,
  input wire logic timer_compare_output_one,
  input wire logic timer_compare_output_two,
  input wire logic aux_clock,
  output logic timer_external_clock_in,
  output logic timer_alternate_clock_in,
  output logic chan0_capture_input_first,
  output logic chan1_capture_input_first,
  output logic chan2_capture_input_first,
  output logic chan0_capture_input_second,
  output logic chan1_capture_input_second,
  output logic p1_irq,
  output logic p2_irq
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [1:0][7:0] pin_output_value;
  logic [1:0][7:0] pin_direction_bit;
  logic [1:0][7:0] pin_irq_flag;
  logic [1:0][7:0] pin_edge_select;
  logic [1:0][7:0] pin_irq_enable;
  logic [1:0][7:0] pin_function_select;
  logic [1:0][7:0] pin_prev;
  logic primed;

  logic [1:0][7:0] pin_input_value;
  logic [1:0][7:0] pin_mask;
  logic [1:0][7:0] edge_hit;
  logic [1:0][7:0] module_out;
  logic port_sel;
  logic [2:0] reg_idx;
  logic mapped;
  logic wr_access;

  assign pin_input_value[0] = p1_in;
  assign pin_input_value[1] = {2'b00, p2_in};
  assign pin_mask[0] = ppfm_pkg::P1_PIN_MASK;
  assign pin_mask[1] = ppfm_pkg::P2_PIN_MASK;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign port_sel = paddr[ppfm_pkg::PORT_BIT];
  assign reg_idx = paddr[ppfm_pkg::REG_IDX_HI:ppfm_pkg::REG_IDX_LO];
  assign mapped = (paddr < ppfm_pkg::MAP_END) && (paddr[1:0] == 2'h0) && (reg_idx <= ppfm_pkg::REG_LAST);
  assign wr_access = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read data is captured in the setup cycle so it stands through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (psel && !penable && !pwrite)
    begin
      if (!mapped)
      begin
        prdata <= 32'h00000000;
      end
      else if (reg_idx == ppfm_pkg::REG_INPUT)
      begin
        prdata <= {ppfm_pkg::READ_PAD, pin_input_value[port_sel] & pin_mask[port_sel]};
      end
      else if (reg_idx == ppfm_pkg::REG_OUTPUT)
      begin
        prdata <= {ppfm_pkg::READ_PAD, pin_output_value[port_sel]};
      end
      else if (reg_idx == ppfm_pkg::REG_DIRECTION)
      begin
        prdata <= {ppfm_pkg::READ_PAD, pin_direction_bit[port_sel]};
      end
      else if (reg_idx == ppfm_pkg::REG_IRQ_FLAG)
      begin
        prdata <= {ppfm_pkg::READ_PAD, pin_irq_flag[port_sel]};
      end
      else if (reg_idx == ppfm_pkg::REG_EDGE_SELECT)
      begin
        prdata <= {ppfm_pkg::READ_PAD, pin_edge_select[port_sel]};
      end
      else if (reg_idx == ppfm_pkg::REG_IRQ_ENABLE)
      begin
        prdata <= {ppfm_pkg::READ_PAD, pin_irq_enable[port_sel]};
      end
      else
      begin
        prdata <= {ppfm_pkg::READ_PAD, pin_function_select[port_sel]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Pinless bits keep full storage like any other bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_output_value <= {2{ppfm_pkg::RESET_BYTE}};
      pin_direction_bit <= {2{ppfm_pkg::RESET_BYTE}};
      pin_edge_select <= {2{ppfm_pkg::RESET_BYTE}};
      pin_irq_enable <= {2{ppfm_pkg::RESET_BYTE}};
      pin_function_select <= {2{ppfm_pkg::RESET_BYTE}};
    end
    else if (wr_access)
    begin
      if (reg_idx == ppfm_pkg::REG_OUTPUT)
      begin
        pin_output_value[port_sel] <= pwdata[7:0];
      end
      else if (reg_idx == ppfm_pkg::REG_DIRECTION)
      begin
        pin_direction_bit[port_sel] <= pwdata[7:0];
      end
      else if (reg_idx == ppfm_pkg::REG_EDGE_SELECT)
      begin
        pin_edge_select[port_sel] <= pwdata[7:0];
      end
      else if (reg_idx == ppfm_pkg::REG_IRQ_ENABLE)
      begin
        pin_irq_enable[port_sel] <= pwdata[7:0];
      end
      else if (reg_idx == ppfm_pkg::REG_FUNCTION_SELECT)
      begin
        pin_function_select[port_sel] <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and interrupt flags
  // ----------------------------------------------------------------
  // Edges are ignored on the first cycle after reset so a pin already high is not an edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_prev <= {2{ppfm_pkg::RESET_BYTE}};
      primed <= 1'b0;
    end
    else
    begin
      pin_prev <= pin_input_value;
      primed <= 1'b1;
    end
  end

  generate
    for (genvar p = 0; p < ppfm_pkg::PORT_COUNT; p++)
    begin : g_edge
      // Masking keeps pinless bits software-only
      assign edge_hit[p] = {8{primed}} & pin_mask[p] & pin_irq_enable[p] &
        ((pin_edge_select[p] & pin_prev[p] & ~pin_input_value[p]) |
         (~pin_edge_select[p] & ~pin_prev[p] & pin_input_value[p]));
    end
  endgenerate

  // Hardware set wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_irq_flag <= {2{ppfm_pkg::RESET_BYTE}};
    end
    else
    begin
      for (int p = 0; p < ppfm_pkg::PORT_COUNT; p++)
      begin
        if (wr_access && reg_idx == ppfm_pkg::REG_IRQ_FLAG && port_sel == p[0])
        begin
          pin_irq_flag[p] <= pwdata[7:0] | edge_hit[p];
        end
        else
        begin
          pin_irq_flag[p] <= pin_irq_flag[p] | edge_hit[p];
        end
      end
    end
  end

  assign p1_irq = |(pin_irq_flag[0] & pin_irq_enable[0]);
  assign p2_irq = |(pin_irq_flag[1] & pin_irq_enable[1]);

  // ----------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------
  assign module_out[0] = {4'h0, timer_compare_output_two, timer_compare_output_one,
                          timer_compare_output_zero, 1'b0};
  assign module_out[1] = {3'h0, timer_compare_output_two, timer_compare_output_one,
                          timer_compare_output_zero, 1'b0, aux_clock};

  assign p1_out = (pin_function_select[0] & module_out[0]) | (~pin_function_select[0] & pin_output_value[0]);
  assign p2_out = (pin_function_select[1][5:0] & module_out[1][5:0]) |
                  (~pin_function_select[1][5:0] & pin_output_value[1][5:0]);
  assign p1_oe = pin_direction_bit[0];
  assign p2_oe = pin_direction_bit[1][5:0];

  assign timer_external_clock_in = pin_function_select[0][0] & p1_in[0];
  assign chan0_capture_input_first = pin_function_select[0][1] & p1_in[1];
  assign chan1_capture_input_first = pin_function_select[0][2] & p1_in[2];
  assign chan2_capture_input_first = pin_function_select[0][3] & p1_in[3];
  assign timer_alternate_clock_in = pin_function_select[1][1] & p2_in[1];
  assign chan0_capture_input_second = pin_function_select[1][2] & p2_in[2];
  assign chan1_capture_input_second = pin_function_select[1][3] & p2_in[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_dir_follows_bit: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && reg_idx == ppfm_pkg::REG_DIRECTION |=>
    ($past(port_sel) ? p2_oe == $past(pwdata[5:0]) : p1_oe == $past(pwdata[7:0])))
    else $error("pin enable differs from direction bit");

  a_p1_bit0_low: assert property (@(posedge pclk) disable iff (!presetn)
    pin_function_select[0][0] |-> !p1_out[0] && timer_external_clock_in == p1_in[0])
    else $error("port1 bit0 module path wrong");

  a_p1_compare_route: assert property (@(posedge pclk) disable iff (!presetn)
    pin_function_select[0][3:1] == 3'h7 |->
    p1_out[3:1] == {timer_compare_output_two, timer_compare_output_one, timer_compare_output_zero}
    && chan2_capture_input_first == p1_in[3])
    else $error("port1 compare routing wrong");

  a_aux_clock_drive: assert property (@(posedge pclk) disable iff (!presetn)
    pin_function_select[1][0] |-> p2_out[0] == aux_clock)
    else $error("aux clock not on port2 bit0");

  a_alt_clock_route: assert property (@(posedge pclk) disable iff (!presetn)
    pin_function_select[1][1] |-> !p2_out[1] && timer_alternate_clock_in == p2_in[1])
    else $error("port2 bit1 module path wrong");

  a_p2_compare_route: assert property (@(posedge pclk) disable iff (!presetn)
    pin_function_select[1][4:2] == 3'h7 |->
    p2_out[4:2] == {timer_compare_output_two, timer_compare_output_one, timer_compare_output_zero}
    && chan1_capture_input_second == p2_in[3])
    else $error("port2 compare routing wrong");

  a_pinless_store: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && reg_idx == ppfm_pkg::REG_DIRECTION && port_sel |=> pin_direction_bit[1][7:6] == $past(pwdata[7:6]))
    else $error("pinless control bits not stored");

  a_soft_flag_only: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_access && reg_idx == ppfm_pkg::REG_IRQ_FLAG && port_sel) |=> $stable(pin_irq_flag[1][7:6]))
    else $error("pinless flag changed without write");

  a_edge_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    primed && !pin_prev[0][0] && p1_in[0] && pin_irq_enable[0][0] && !pin_edge_select[0][0]
    |=> pin_irq_flag[0][0] ##0 p1_irq)
    else $error("rising edge did not set flag");

endmodule : ppfm_port_mux

//--- shared/ppfm_pkg.sv
// Constants for the two-port pin function multiplexer.
// Assumes an APB master with 32-bit data and word-aligned addresses.
package ppfm_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned PORT_COUNT = 2;
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned P1_PIN_COUNT = 8;
  localparam int unsigned P2_PIN_COUNT = 6;
  localparam int unsigned ADDR_WIDTH = 12;
  localparam int unsigned DATA_WIDTH = 32;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] PORT_STRIDE = 12'h020;
  localparam logic [11:0] MAP_END = 12'h040;
  localparam logic [2:0] REG_INPUT = 3'h0;
  localparam logic [2:0] REG_OUTPUT = 3'h1;
  localparam logic [2:0] REG_DIRECTION = 3'h2;
  localparam logic [2:0] REG_IRQ_FLAG = 3'h3;
  localparam logic [2:0] REG_EDGE_SELECT = 3'h4;
  localparam logic [2:0] REG_IRQ_ENABLE = 3'h5;
  localparam logic [2:0] REG_FUNCTION_SELECT = 3'h6;
  localparam logic [2:0] REG_LAST = 3'h6;
  localparam int unsigned PORT_BIT = 5;
  localparam int unsigned REG_IDX_HI = 4;
  localparam int unsigned REG_IDX_LO = 2;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] P1_PIN_MASK = 8'hff;
  localparam logic [7:0] P2_PIN_MASK = 8'h3f;
  localparam logic [23:0] READ_PAD = 24'h000000;

endpackage : ppfm_pkg

//--- testbench/ppfm_board_model.sv
// Board pins for the two-port pin function multiplexer bench.
// Assumes the bench sets the board levels; no pull-ups, a driven pin wins.
`timescale 1ns/1ps

module ppfm_board_model
(
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe,
  input wire logic [5:0] p2_out,
  input wire logic [5:0] p2_oe,
  input wire logic [7:0] ext1,
  input wire logic [5:0] ext2,
  output logic [7:0] p1_in,
  output logic [5:0] p2_in
);
  // --------------------------------------------------------------
  // Pin resolution: driven bits read back the device's own level
  // --------------------------------------------------------------
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & ext1);
  assign p2_in = (p2_oe & p2_out) | (~p2_oe & ext2);
endmodule : ppfm_board_model

//--- testbench/tb.sv
// Self-checking bench for the two-port pin function multiplexer.
// Assumes the board model closes the pin loop; the bench plays timer and APB master.
`timescale 1ns/1ps

module tb;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  localparam logic [2:0] IN = ppfm_pkg::REG_INPUT;
  localparam logic [2:0] OUT = ppfm_pkg::REG_OUTPUT;
  localparam logic [2:0] DIR = ppfm_pkg::REG_DIRECTION;
  localparam logic [2:0] FLG = ppfm_pkg::REG_IRQ_FLAG;
  localparam logic [2:0] ES = ppfm_pkg::REG_EDGE_SELECT;
  localparam logic [2:0] IE = ppfm_pkg::REG_IRQ_ENABLE;
  localparam logic [2:0] SEL = ppfm_pkg::REG_FUNCTION_SELECT;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, aux_clock, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [7:0] p1_in, p1_out, p1_oe, ext1;
  logic [5:0] p2_in, p2_out, p2_oe, ext2;
  logic [2:0] cmp;
  logic timer_external_clock_in, timer_alternate_clock_in, p1_irq, p2_irq;
  logic chan0_capture_input_first, chan1_capture_input_first, chan2_capture_input_first;
  logic chan0_capture_input_second, chan1_capture_input_second;
  int fails = 0;
  int checks = 0;
  int cyc = 0;

  ppfm_port_mux u_dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .p1_in, .p1_out, .p1_oe, .p2_in, .p2_out, .p2_oe, .aux_clock,
    .timer_compare_output_zero(cmp[0]), .timer_compare_output_one(cmp[1]),
    .timer_compare_output_two(cmp[2]), .timer_external_clock_in, .timer_alternate_clock_in,
    .chan0_capture_input_first, .chan1_capture_input_first, .chan2_capture_input_first,
    .chan0_capture_input_second, .chan1_capture_input_second, .p1_irq, .p2_irq
  );

  ppfm_board_model u_board
  (
    .p1_out, .p1_oe, .p2_out, .p2_oe, .ext1, .ext2, .p1_in, .p2_in
  );

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [11:0] ra(input logic p, input logic [2:0] r);
    return (p ? ppfm_pkg::PORT_STRIDE : 12'h000) + {7'h00, r, 2'b00};
  endfunction : ra

  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, v};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic p, input logic [2:0] r, input logic [7:0] v);
    apb(1'b1, ra(p, r), v);
  endtask : wr

  task automatic rdc(input logic p, input logic [2:0] r, input logic [7:0] exp);
    apb(1'b0, ra(p, r), 8'h00);
    chk(d, {24'h000000, exp});
  endtask : rdc

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // --------------------------------------------------------------
  // Clock, watchdog and scenarios
  // --------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails = fails + 1;
      give_verdict();
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ext1 = 8'h00;
    ext2 = 6'h00;
    cmp = 3'h0;
    aux_clock = 1'b0;
    tick(10);
    presetn <= 1'b1;
    tick(1);
    rdc(1'b0, DIR, 8'h00);
    chk(p1_oe, 8'h00);
    wr(1'b0, DIR, 8'hff);
    wr(1'b0, OUT, 8'ha5);
    chk(p1_out, 8'ha5);
    rdc(1'b0, IN, 8'ha5);
    cmp <= 3'b101;
    wr(1'b0, SEL, 8'h0f);
    chk(p1_out, 8'haa);
    chk(p1_oe, 8'hff);
    wr(1'b0, DIR, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      ext1 <= i ? 8'h05 : 8'h0a;
      tick(1);
      chk({chan2_capture_input_first, chan1_capture_input_first, chan0_capture_input_first,
           timer_external_clock_in}, i ? 4'h5 : 4'ha);
    end
    wr(1'b0, SEL, 8'h00);
    chk({chan0_capture_input_first, timer_external_clock_in}, 2'b00);
    rdc(1'b0, FLG, 8'h00);
    aux_clock <= 1'b1;
    wr(1'b1, DIR, 8'h1f);
    wr(1'b1, SEL, 8'h1f);
    chk(p2_out, 6'h15);
    chk(p2_oe, 6'h1f);
    aux_clock <= 1'b0;
    wr(1'b1, DIR, 8'h00);
    ext2 <= 6'h1e;
    tick(1);
    chk({chan1_capture_input_second, chan0_capture_input_second, timer_alternate_clock_in}, 3'h7);
    wr(1'b1, SEL, 8'hc0);
    rdc(1'b1, SEL, 8'hc0);
    wr(1'b1, DIR, 8'hc0);
    rdc(1'b1, DIR, 8'hc0);
    rdc(1'b1, IN, 8'h1e);
    wr(1'b1, IE, 8'hc0);
    wr(1'b1, FLG, 8'hc0);
    chk(p2_irq, 1'b1);
    wr(1'b1, FLG, 8'h00);
    chk(p2_irq, 1'b0);
    ext1 <= 8'h00;
    wr(1'b0, IE, 8'h01);
    wr(1'b0, FLG, 8'h00);
    ext1 <= 8'h01;
    tick(2);
    chk(p1_irq, 1'b1);
    wr(1'b0, ES, 8'h01);
    wr(1'b0, FLG, 8'h00);
    ext1 <= 8'h00;
    tick(2);
    rdc(1'b0, FLG, 8'h01);
    wr(1'b0, FLG, 8'h00);
    ext1 <= 8'h01;
    tick(2);
    rdc(1'b0, FLG, 8'h00);
    apb(1'b0, 12'h03c, 8'h00);
    chk(e, 1'b1);
    chk(d, 32'h00000000);
    give_verdict();
  end
endmodule : tb
